// File: design/tmr_core.sv
// 16-bit timer/counter with shared high-byte holding register
// How it works
// RULE1: Counter, compares, capture are 16-bit byte pairs
// RULE2: One shared 8-bit high-byte holding register
// RULE3: Low-byte write loads holding plus low byte
// RULE4: Low-byte read copies high byte to holding
// RULE5: Compare high reads bypass the holding register
// RULE6: Host writes high first, reads low first
// RULE7: Tick from prescaler or pin edge; none stops
// RULE8: Compare matches set compare flags
// RULE9: Compare results drive waveform output pins
// RULE10: Capture edge stores counter into capture
// RULE11: Capture input passes a noise filter
// RULE12: TOP fixed, compare A or capture by mode
// RULE13: Compare A as TOP is double buffered in PWM modes; CTC loads it immediately
// RULE14: Zero is item_a, all ones is max
// RULE15: Four flags visible, each masked individually
// RULE16: Control registers plain 8-bit read/write
// RULE17: Host counter write beats count and clear
// RULE18: Counter clears, increments or decrements per tick
// RULE19: High-byte write only loads holding register
// RULE20: Count/capture high read returns holding register
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"
module tmr_core #(
    parameter int NC_SAMPLES = `TMR_NC_SAMPLES
) (
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst_n,
    input  wire logic [`TMR_ADDR_W-1:0] i_addr,
    input  wire tmr_pkg::tmr_byte_type  i_wdata,
    input  wire logic                   i_wr,
    input  wire logic                   i_rd,
    input  wire logic                   i_external_count_pin,
    input  wire logic                   i_capture_input_pin,
    input  wire logic                   i_comparator_out,
    output var tmr_pkg::tmr_byte_type   o_rdata,
    output logic                        o_compare_output_a,
    output logic                        o_compare_output_b,
    output logic [3:0]                  o_irq_request
);
    import tmr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic [1:0] ext_sync_q, icp_sync_q, acp_sync_q;
    logic       ext_prev_q;

    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_sync_q <= 2'b00;
            icp_sync_q <= 2'b00;
            acp_sync_q <= 2'b00;
            ext_prev_q <= 1'b0;
        end else begin
            ext_sync_q <= {ext_sync_q[0], i_external_count_pin};
            icp_sync_q <= {icp_sync_q[0], i_capture_input_pin};
            acp_sync_q <= {acp_sync_q[0], i_comparator_out};
            ext_prev_q <= ext_sync_q[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and address decode
    tmr_byte_type control_a_q, control_b_q, holding_q;
    tmr_byte_type irq_mask_reg_q;
    logic [3:0]   irq_flag_reg_q;
    logic [15:0]  count_value_q, compare_value_a_q, compare_value_b_q;
    logic [15:0]  cmpa_buf_q, cmpb_buf_q, capture_value_q;
    logic [9:0]   pre_cnt_q;

    function automatic logic hit(input logic [`TMR_ADDR_W-1:0] off,
                                 input logic [`TMR_ADDR_W-1:0] a);
        return a == off;
    endfunction

    wire         wr_cnt_l  = i_wr && hit(`TMR_OFF_CNT_L, i_addr);
    wire         wr_cmpa_l = i_wr && hit(`TMR_OFF_CMPA_L, i_addr);
    wire         wr_cmpb_l = i_wr && hit(`TMR_OFF_CMPB_L, i_addr);
    wire         wr_cap_l  = i_wr && hit(`TMR_OFF_CAP_L, i_addr);
    wire         wr_high   = i_wr && i_addr[0] && (i_addr >= `TMR_OFF_CNT_H)
                             && (i_addr <= `TMR_OFF_CAP_H);
    wire         rd_cnt_l  = i_rd && hit(`TMR_OFF_CNT_L, i_addr);
    wire         rd_cap_l  = i_rd && hit(`TMR_OFF_CAP_L, i_addr);
    wire [15:0]  wr_word   = {holding_q, i_wdata}; // RULE3

    wire tmr_cs_type  cs  = tmr_cs_type'(control_b_q[`TMR_CTRLB_CS_LSB +: 3]);
    wire tmr_wgm_type wgm =
        tmr_wgm_type'(control_b_q[`TMR_CTRLB_WGM_LSB +: 2]);
    wire [1:0]   top_sel  = control_a_q[3:2];

    ////////////////////////////////////////////////////////////////////////
    // Clock select and prescaler
    logic tick;
    always_comb begin
        case (cs) // RULE7
            TMR_CS_STOP: tick = 1'b0;
            TMR_CS_DIV1: tick = 1'b1;
            TMR_CS_DIV8: tick = pre_cnt_q[2:0] == 3'h7;
            TMR_CS_D64:  tick = pre_cnt_q[5:0] == 6'h3f;
            TMR_CS_D256: tick = pre_cnt_q[7:0] == 8'hff;
            TMR_CS_D1K:  tick = pre_cnt_q == 10'h3ff;
            TMR_CS_EXTF: tick = ext_prev_q && !ext_sync_q[1];
            TMR_CS_EXTR: tick = !ext_prev_q && ext_sync_q[1];
            default:     tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // TOP selection and counting
    logic [15:0] top;
    always_comb begin
        if (wgm == TMR_WGM_NORMAL) begin
            top = `TMR_MAX; // RULE14
        end else if (wgm == TMR_WGM_CTCA || top_sel == 2'b11) begin
            top = compare_value_a_q; // RULE12
        end else begin
            case (top_sel) // RULE12
                2'b00:   top = `TMR_TOP_8;
                2'b01:   top = `TMR_TOP_9;
                2'b10:   top = `TMR_TOP_10;
                default: top = capture_value_q;
            endcase
        end
    end
    wire use_a_top = (wgm != TMR_WGM_NORMAL) &&
                     (wgm == TMR_WGM_CTCA || top_sel == 2'b11);
    wire use_cap_top = (wgm == TMR_WGM_PWM || wgm == TMR_WGM_PCPWM) &&
                       top_sel == 2'b00 && control_a_q[4];
    wire [15:0] top_eff = use_cap_top ? capture_value_q : top;

    logic        dir_down_q;
    wire at_top    = count_value_q == top_eff;
    wire at_item_a = count_value_q == `TMR_ITEM_A; // RULE14
    wire pcpwm     = wgm == TMR_WGM_PCPWM;
    logic [15:0] cnt_next;
    logic        ovf_ev;
    always_comb begin
        cnt_next = count_value_q + 16'h0001; // RULE18
        ovf_ev   = 1'b0;
        if (pcpwm) begin
            if (dir_down_q) begin
                cnt_next = count_value_q - 16'h0001;
                ovf_ev   = count_value_q == 16'h0001;
            end
            if (at_top) begin
                cnt_next = count_value_q - 16'h0001;
            end
        end else if (at_top) begin
            cnt_next = `TMR_ITEM_A;
            ovf_ev   = wgm != TMR_WGM_CTCA;
        end
    end

    // Buffered compares load at top (PWM) or immediately otherwise
    wire pwm_mode  = wgm == TMR_WGM_PWM || pcpwm;
    wire buf_load  = !pwm_mode || (tick && at_top);
    wire match_a   = tick && count_value_q == compare_value_a_q; // RULE8
    wire match_b   = tick && count_value_q == compare_value_b_q; // RULE8

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_value_q <= `TMR_ITEM_A;
            dir_down_q    <= 1'b0;
            pre_cnt_q     <= 10'h000;
        end else begin
            pre_cnt_q <= (cs == TMR_CS_STOP) ? 10'h000 : pre_cnt_q + 10'h001;
            if (wr_cnt_l) begin
                count_value_q <= wr_word; // RULE17
            end else if (tick) begin
                count_value_q <= cnt_next; // RULE18
                if (pcpwm && at_top) begin
                    dir_down_q <= 1'b1;
                end else if (pcpwm && count_value_q == 16'h0001 &&
                             dir_down_q) begin
                    dir_down_q <= 1'b0;
                end else if (!pcpwm) begin
                    dir_down_q <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare buffers, capture, noise filter
    logic [NC_SAMPLES-1:0] nc_hist_q;
    logic                  cap_lvl_q, cap_prev_q;
    wire cap_raw = control_b_q[`TMR_CTRLB_CAPSRC] ? acp_sync_q[1]
                                                   : icp_sync_q[1];
    wire nc_all1 = &nc_hist_q;
    wire nc_all0 = ~|nc_hist_q;
    wire cap_in  = control_b_q[`TMR_CTRLB_NCE] ? cap_lvl_q : cap_raw;
    wire cap_ev  = (cap_in != cap_prev_q) &&
                   (cap_in == control_b_q[`TMR_CTRLB_CAPEDGE]);
    wire cap_store = cap_ev && !use_cap_top;

    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            compare_value_a_q <= `TMR_ITEM_A;
            compare_value_b_q <= `TMR_ITEM_A;
            cmpa_buf_q        <= `TMR_ITEM_A;
            cmpb_buf_q        <= `TMR_ITEM_A;
            capture_value_q   <= `TMR_ITEM_A;
            nc_hist_q         <= '0;
            cap_lvl_q         <= 1'b0;
            cap_prev_q        <= 1'b0;
        end else begin
            if (wr_cmpa_l) cmpa_buf_q <= wr_word; // RULE1
            if (wr_cmpb_l) cmpb_buf_q <= wr_word;
            if (buf_load) begin
                compare_value_a_q <= cmpa_buf_q; // RULE13
                compare_value_b_q <= cmpb_buf_q;
            end
            nc_hist_q <= {nc_hist_q[NC_SAMPLES-2:0], cap_raw}; // RULE11
            if (nc_all1) cap_lvl_q <= 1'b1;
            else if (nc_all0) cap_lvl_q <= 1'b0;
            cap_prev_q <= cap_in;
            if (wr_cap_l) begin
                capture_value_q <= wr_word;
            end else if (cap_store) begin
                capture_value_q <= count_value_q; // RULE10
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Holding register, flags, control, read data
    wire [3:0] flag_set = {cap_ev, match_b, match_a, tick && ovf_ev};
    wire [3:0] flag_clr = (i_wr && hit(`TMR_OFF_FLAG, i_addr))
                          ? i_wdata[3:0] : 4'h0;
    logic [7:0] rd_mux;
    always_comb begin
        case (i_addr)
            `TMR_OFF_CTRL_A: rd_mux = control_a_q; // RULE16
            `TMR_OFF_CTRL_B: rd_mux = control_b_q;
            `TMR_OFF_CNT_L:  rd_mux = count_value_q[7:0];
            `TMR_OFF_CNT_H:  rd_mux = holding_q; // RULE20
            `TMR_OFF_CMPA_L: rd_mux = cmpa_buf_q[7:0];
            `TMR_OFF_CMPA_H: rd_mux = cmpa_buf_q[15:8]; // RULE5
            `TMR_OFF_CMPB_L: rd_mux = cmpb_buf_q[7:0];
            `TMR_OFF_CMPB_H: rd_mux = cmpb_buf_q[15:8]; // RULE5
            `TMR_OFF_CAP_L:  rd_mux = capture_value_q[7:0];
            `TMR_OFF_CAP_H:  rd_mux = holding_q; // RULE20
            `TMR_OFF_FLAG:   rd_mux = {4'h0, irq_flag_reg_q};
            `TMR_OFF_MASK:   rd_mux = {4'h0, irq_mask_reg_q[3:0]};
            default:         rd_mux = 8'h00;
        endcase
    end

    logic oca_q, ocb_q;
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            holding_q      <= `TMR_RST_BYTE;
            control_a_q    <= `TMR_RST_BYTE;
            control_b_q    <= `TMR_RST_BYTE;
            irq_mask_reg_q <= `TMR_RST_BYTE;
            irq_flag_reg_q <= 4'h0;
            o_rdata        <= 8'h00;
            o_irq_request  <= 4'h0;
            oca_q          <= 1'b0;
            ocb_q          <= 1'b0;
        end else begin
            if (wr_high) begin
                holding_q <= i_wdata; // RULE19 RULE2
            end else if (rd_cnt_l) begin
                holding_q <= count_value_q[15:8]; // RULE4
            end else if (rd_cap_l) begin
                holding_q <= capture_value_q[15:8]; // RULE4
            end
            if (i_wr && hit(`TMR_OFF_CTRL_A, i_addr)) control_a_q <= i_wdata;
            if (i_wr && hit(`TMR_OFF_CTRL_B, i_addr)) control_b_q <= i_wdata;
            if (i_wr && hit(`TMR_OFF_MASK, i_addr)) begin
                irq_mask_reg_q <= {4'h0, i_wdata[3:0]};
            end
            // Set wins over write-one-to-clear
            irq_flag_reg_q <= (irq_flag_reg_q & ~flag_clr) | flag_set;
            o_irq_request  <= irq_flag_reg_q & irq_mask_reg_q[3:0]; // RULE15
            o_rdata <= i_rd ? rd_mux : 8'h00;
            // Toggle on match or set-at-item_a/clear-on-match PWM
            if (pwm_mode) begin
                oca_q <= use_a_top ? 1'b0
                         : (count_value_q < compare_value_a_q); // RULE9 RULE13
                ocb_q <= count_value_q < compare_value_b_q; // RULE9
            end else begin
                if (match_a && control_a_q[`TMR_CTRLA_WAVA]) oca_q <= !oca_q;
                if (match_b && control_a_q[`TMR_CTRLA_WAVB]) ocb_q <= !ocb_q;
            end
        end
    end
    assign o_compare_output_a = oca_q;
    assign o_compare_output_b = ocb_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_low_write; // RULE3
        @(posedge i_clk_sys) disable iff (!rst_n)
        wr_cnt_l |=> count_value_q == $past(wr_word);
    endproperty
    a_low_write: assert property (p_low_write) // RULE3
        else $error("count low write did not load word");
    property p_low_read; // RULE4
        @(posedge i_clk_sys) disable iff (!rst_n)
        rd_cnt_l && !i_wr |=> holding_q == $past(count_value_q[15:8]);
    endproperty
    a_low_read: assert property (p_low_read) // RULE4
        else $error("holding not loaded on low read");
    property p_high_write; // RULE19
        @(posedge i_clk_sys) disable iff (!rst_n)
        wr_high && !tick |=> count_value_q == $past(count_value_q);
    endproperty
    a_high_write: assert property (p_high_write) // RULE19
        else $error("high write changed counter");
    property p_stop; // RULE7
        @(posedge i_clk_sys) disable iff (!rst_n)
        cs == TMR_CS_STOP && !wr_cnt_l |=> $stable(count_value_q);
    endproperty
    a_stop: assert property (p_stop) // RULE7
        else $error("counter moved with no source");
    property p_flag_a; // RULE8
        @(posedge i_clk_sys) disable iff (!rst_n)
        match_a |=> irq_flag_reg_q[`TMR_FLD_CMPA];
    endproperty
    a_flag_a: assert property (p_flag_a) // RULE8
        else $error("compare flag a missing");
    property p_capture; // RULE10
        @(posedge i_clk_sys) disable iff (!rst_n)
        cap_store && !wr_cap_l |=> capture_value_q == $past(count_value_q);
    endproperty
    a_capture: assert property (p_capture) // RULE10
        else $error("capture did not store counter");
    property p_irq; // RULE15
        @(posedge i_clk_sys) disable iff (!rst_n)
        ##1 o_irq_request == $past(irq_flag_reg_q & irq_mask_reg_q[3:0]);
    endproperty
    a_irq: assert property (p_irq) // RULE15
        else $error("interrupt request not masked flag");
    property p_rdata_cmpa; // RULE5
        @(posedge i_clk_sys) disable iff (!rst_n)
        i_rd && i_addr==`TMR_OFF_CMPA_H |=> o_rdata == $past(cmpa_buf_q[15:8]);
    endproperty
    a_rdata_cmpa: assert property (p_rdata_cmpa) // RULE5
        else $error("compare high read wrong");
    c_capture: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
        cap_store);
    c_ovf: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
        tick && ovf_ev);
    c_pair: cover property (@(posedge i_clk_sys) disable iff (!rst_n)
        wr_high ##1 wr_cnt_l);
endmodule
`default_nettype wire

// File: design/tmr_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH
`define TMR_ADDR_W        4
`define TMR_OFF_CTRL_A    4'h0
`define TMR_OFF_CTRL_B    4'h1
`define TMR_OFF_CNT_L     4'h2
`define TMR_OFF_CNT_H     4'h3
`define TMR_OFF_CMPA_L    4'h4
`define TMR_OFF_CMPA_H    4'h5
`define TMR_OFF_CMPB_L    4'h6
`define TMR_OFF_CMPB_H    4'h7
`define TMR_OFF_CAP_L     4'h8
`define TMR_OFF_CAP_H     4'h9
`define TMR_OFF_FLAG      4'ha
`define TMR_OFF_MASK      4'hb
`define TMR_FLD_OVF       0
`define TMR_FLD_CMPA      1
`define TMR_FLD_CMPB      2
`define TMR_FLD_CAP       3
`define TMR_CTRLB_CS_LSB  0
`define TMR_CTRLB_WGM_LSB 3
`define TMR_CTRLB_CAPEDGE 5
`define TMR_CTRLB_NCE     6
`define TMR_CTRLB_CAPSRC  7
`define TMR_CTRLA_WAVA    0
`define TMR_CTRLA_WAVB    1
`define TMR_RST_BYTE      8'h00
`define TMR_ITEM_A        16'h0000
`define TMR_MAX           16'hffff
`define TMR_TOP_8         16'h00ff
`define TMR_TOP_9         16'h01ff
`define TMR_TOP_10        16'h03ff
`define TMR_NC_SAMPLES    4
`endif

// File: design/tmr_pkg.sv
// Types shared by the timer design
package tmr_pkg;
    typedef enum logic [2:0] {
        TMR_CS_STOP = 3'b000,
        TMR_CS_DIV1 = 3'b001,
        TMR_CS_DIV8 = 3'b010,
        TMR_CS_D64  = 3'b011,
        TMR_CS_D256 = 3'b100,
        TMR_CS_D1K  = 3'b101,
        TMR_CS_EXTF = 3'b110,
        TMR_CS_EXTR = 3'b111
    } tmr_cs_type;
    typedef enum logic [1:0] {
        TMR_WGM_NORMAL = 2'b00,
        TMR_WGM_CTCA   = 2'b01,
        TMR_WGM_PWM    = 2'b10,
        TMR_WGM_PCPWM  = 2'b11
    } tmr_wgm_type;
    typedef logic [7:0] tmr_byte_type;
endpackage

// File: dv/timer16_core_byte_access_bench.sv
// Self-checking bench for the timer core
`timescale 1ns/1ps
`default_nettype none
`include "tmr_defs.svh"
module timer16_core_byte_access_bench;
    import tmr_pkg::*;
    typedef struct {string nm; logic [7:0] ex; logic [7:0] mk;} tmr_note_type;
    logic         i_clk_sys  = 1'b0;
    logic         i_rst_n    = 1'b0;
    logic         ext_pin    = 1'b0;
    logic         cap_pin    = 1'b0;
    logic         cmp_out    = 1'b0;
    logic         rd_seen    = 1'b0;
    logic [3:0]   addr;
    logic [7:0]   wdata;
    logic         wr;
    logic         rd;
    tmr_byte_type rdata;
    logic         out_a;
    logic         out_b;
    logic [3:0]   irq;
    logic [15:0]  v;
    int           error_cnt  = 0;
    int           num_checks = 0;
    int           cycles     = 0;
    tmr_note_type notes[$];
    // Fast PWM at three fixed tops, CTC on compare A, phase correct, /8
    logic [7:0]   ctla [6]   = '{8'h00, 8'h04, 8'h08, 8'h00, 8'h00, 8'h00};
    logic [7:0]   ctlb [6]   = '{8'h11, 8'h11, 8'h11, 8'h09, 8'h19, 8'h02};
    // Counter after 900 system cycles in each of those settings
    logic [15:0]  top_ex [6] = '{16'h0084, 16'h0184, 16'h0384, 16'h0010,
                                 16'h0078, 16'h0070};
    logic [7:0]   cs_tab [3] = '{8'h00, 8'h07, 8'h06};

    always #12.5 i_clk_sys = ~i_clk_sys;

    tmr_host_model tmr_host_model_inst (
        .i_clk_sys (i_clk_sys),
        .o_addr    (addr),
        .o_wdata   (wdata),
        .o_wr      (wr),
        .o_rd      (rd)
    );
    tmr_core #(.NC_SAMPLES(4)) tmr_core_inst (
        .i_clk_sys            (i_clk_sys),
        .i_rst_n              (i_rst_n),
        .i_addr               (addr),
        .i_wdata              (wdata),
        .i_wr                 (wr),
        .i_rd                 (rd),
        .i_external_count_pin (ext_pin),
        .i_capture_input_pin  (cap_pin),
        .i_comparator_out     (cmp_out),
        .o_rdata              (rdata),
        .o_compare_output_a   (out_a),
        .o_compare_output_b   (out_b),
        .o_irq_request        (irq)
    );
    ////////////////////////////////////////////////////////////////////////
    task automatic check(string nm, logic [7:0] ex, logic [7:0] got,
                         logic [7:0] mk);
        num_checks++;
        if ((got & mk) !== (ex & mk)) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic w(logic [3:0] a, logic [7:0] d);
        tmr_host_model_inst.wr8(a, d);
    endtask
    task automatic idle(int n);
        repeat (n) tmr_host_model_inst.idle();
    endtask
    task automatic rd8(string nm, logic [3:0] a, logic [7:0] ex,
                       logic [7:0] mk = 8'hff);
        notes.push_back('{nm, ex, mk});
        tmr_host_model_inst.rd8(a);
    endtask
    task automatic rd16(string nm, logic [3:0] lo, logic [15:0] ex);
        rd8(nm, lo, ex[7:0]);
        rd8(nm, lo + 4'h1, ex[15:8]);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Read data stand in the cycle after the strobe; also the hang limit
    always @(posedge i_clk_sys) begin
        tmr_note_type n;
        rd_seen <= rd;
        cycles++;
        if (rd_seen && notes.size() > 0) begin
            n = notes.pop_front();
            check(n.nm, n.ex, rdata, n.mk);
        end
        if (cycles == 12000) begin
            error_cnt++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(65));
        repeat (8) @(posedge i_clk_sys);
        check("reset rdata", 8'h00, rdata, 8'hff);
        check("reset irq", 8'h00, {2'h0, out_b, out_a, irq}, 8'hff);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        for (int k = 0; k < 2; k++) begin
            v = 16'($urandom) & 16'hfff8;
            w(4'(k), v[7:0]);
            rd8("control", 4'(k), v[7:0]);
            w(4'(k), 8'h00);
        end
        w(4'hc, 8'hff);
        rd8("unmapped", 4'hc, 8'h00);
        v = 16'($urandom);
        tmr_host_model_inst.wr16(`TMR_OFF_CNT_L, v);
        rd16("count", `TMR_OFF_CNT_L, v);
        w(`TMR_OFF_CNT_H, ~v[15:8]);
        rd8("holding", `TMR_OFF_CNT_H, ~v[15:8]);
        rd16("count kept", `TMR_OFF_CNT_L, v);
        // One high byte serves both compare writes
        w(`TMR_OFF_CMPA_H, 8'h00);
        w(`TMR_OFF_CMPA_L, 8'h10);
        w(`TMR_OFF_CMPB_L, 8'h12);
        w(`TMR_OFF_CNT_H, 8'h5a);
        rd8("cmpa high", `TMR_OFF_CMPA_H, 8'h00);
        rd8("cmpb low", `TMR_OFF_CMPB_L, 8'h12);
        rd8("cmpb high", `TMR_OFF_CMPB_H, 8'h00);
        tmr_host_model_inst.wr16(`TMR_OFF_CNT_L, 16'h000c);
        w(`TMR_OFF_FLAG, 8'h0f);
        w(`TMR_OFF_CTRL_A, 8'h03);
        v[1:0] = {out_b, out_a};
        w(`TMR_OFF_CTRL_B, 8'h01);
        idle(16);
        w(`TMR_OFF_CTRL_B, 8'h00);
        idle(4);
        check("wave", {6'h0, ~v[1:0]}, {6'h0, out_b, out_a}, 8'hff);
        rd8("cmp flags", `TMR_OFF_FLAG, 8'h06, 8'h0f);
        w(`TMR_OFF_MASK, 8'h02);
        idle(3);
        check("irq masked", 8'h02, {4'h0, irq}, 8'hff);
        w(`TMR_OFF_MASK, 8'h0f);
        w(`TMR_OFF_FLAG, 8'h06);
        idle(3);
        check("irq cleared", 8'h00, {4'h0, irq}, 8'hff);
        w(`TMR_OFF_CTRL_A, 8'h00);
        tmr_host_model_inst.wr16(`TMR_OFF_CNT_L, 16'hfff0);
        w(`TMR_OFF_CTRL_B, 8'h01);
        idle(32);
        w(`TMR_OFF_CTRL_B, 8'h00);
        idle(3);
        rd8("ovf flag", `TMR_OFF_FLAG, 8'h01, 8'h01);
        check("ovf irq", 8'h01, {4'h0, irq}, 8'h01);
        rd8("wrap low", `TMR_OFF_CNT_L, 8'h11);
        rd8("wrap high", `TMR_OFF_CNT_H, 8'h00);
        for (int k = 0; k < 3; k++) begin
            tmr_host_model_inst.wr16(`TMR_OFF_CNT_L, 16'h0000);
            w(`TMR_OFF_CTRL_B, cs_tab[k]);
            repeat (5) begin
                ext_pin <= 1'b1;
                idle(4);
                ext_pin <= 1'b0;
                idle(4);
            end
            w(`TMR_OFF_CTRL_B, 8'h00);
            rd16("pin count", `TMR_OFF_CNT_L, 16'(k ? 5 : 0));
        end
        for (int k = 0; k < 6; k++) begin
            tmr_host_model_inst.wr16(`TMR_OFF_CNT_L, 16'h0000);
            w(`TMR_OFF_CTRL_A, ctla[k]);
            w(`TMR_OFF_CTRL_B, ctlb[k]);
            idle(899);
            w(`TMR_OFF_CTRL_B, 8'h00);
            rd16("top count", `TMR_OFF_CNT_L, top_ex[k]);
        end
        w(`TMR_OFF_CTRL_A, 8'h00);
        tmr_host_model_inst.wr16(`TMR_OFF_CNT_L, 16'h0321);
        w(`TMR_OFF_FLAG, 8'h0f);
        w(`TMR_OFF_CTRL_B, 8'h60);
        // A two-cycle spike must not pass the filter
        cap_pin <= 1'b1;
        idle(2);
        cap_pin <= 1'b0;
        idle(12);
        rd8("spike flag", `TMR_OFF_FLAG, 8'h00, 8'h08);
        cap_pin <= 1'b1;
        idle(12);
        rd16("capture", `TMR_OFF_CAP_L, 16'h0321);
        rd8("cap flag", `TMR_OFF_FLAG, 8'h08, 8'h08);
        tmr_host_model_inst.wr16(`TMR_OFF_CNT_L, 16'h0456);
        w(`TMR_OFF_CTRL_B, 8'ha0);
        cmp_out <= 1'b1;
        idle(12);
        rd16("cmp capture", `TMR_OFF_CAP_L, 16'h0456);
        idle(4);
        finish_test();
    end
endmodule
`default_nettype wire

// File: dv/tmr_host_model.sv
// Host bus master model for the timer core
`timescale 1ns/1ps
`default_nettype none
module tmr_host_model (
    input  wire logic       i_clk_sys,
    output logic [3:0]      o_addr,
    output logic [7:0]      o_wdata,
    output logic            o_wr,
    output logic            o_rd
);
    initial begin
        o_addr  = 4'hf;
        o_wdata = 8'h00;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
    end
    // Each call is entered right after an edge and holds through the next
    task automatic wr8(input logic [3:0] a, input logic [7:0] d);
        o_addr  <= a;
        o_wdata <= d;
        o_wr    <= 1'b1;
        o_rd    <= 1'b0;
        @(posedge i_clk_sys);
    endtask
    task automatic rd8(input logic [3:0] a);
        o_addr <= a;
        o_wr   <= 1'b0;
        o_rd   <= 1'b1;
        @(posedge i_clk_sys);
    endtask
    // Released data lines keep changing instead of holding the last byte
    task automatic idle();
        o_wr    <= 1'b0;
        o_rd    <= 1'b0;
        o_wdata <= ~o_wdata;
        @(posedge i_clk_sys);
    endtask
    task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
        wr8(lo + 4'h1, v[15:8]);
        wr8(lo, v[7:0]);
    endtask
endmodule
`default_nettype wire
